// ==== verification/hdlc_host_port_assertions.sv ====
/*
 Port checker for the host command/result block.
 Assumes one clock domain and a synchronous active-high reset.
*/
module hdlc_port_checker (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic host_cs_i,
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   input wire logic [1:0] host_addr_i,
   input wire logic [7:0] host_wdata_i,
   input wire logic rx_transfer_acknowledge_i,
   input wire logic tx_transfer_acknowledge_i,
   input wire logic [7:0] host_rdata_o,
   input wire logic tx_interrupt_request_o,
   input wire logic rx_interrupt_request_o,
   input wire logic irq_transfer_mode_i,
   input wire logic tx_dma_req_o,
   input wire logic cmd_valid_o,
   input wire logic [7:0] cmd_byte_o,
   input wire logic param_valid_o,
   input wire logic [7:0] param_byte_o,
   input wire logic imm_result_valid_i,
   input wire logic [7:0] imm_result_i,
   input wire logic tx_xfer_req_i,
   input wire logic tx_data_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_result_valid_i,
   input wire logic tx_result_ready_o,
   input wire logic rx_result_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [7:0] last_imm_q;
   logic reg_rd;
   logic reg_wr;
   logic dack;
   // Acknowledge inputs steal the strobe from register access
   assign dack = rx_transfer_acknowledge_i | tx_transfer_acknowledge_i;
   assign reg_rd = ce_i & host_cs_i & host_rd_i & ~dack;
   assign reg_wr = ce_i & host_cs_i & host_wr_i & ~dack;
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         last_imm_q <= 8'h00;
      else if (ce_i && imm_result_valid_i)
         last_imm_q <= imm_result_i;
   end
   a_cmd_write_latch: assert property (reg_wr && host_addr_i == 2'h0 |=>
      cmd_valid_o && cmd_byte_o == $past(host_wdata_i)) else $error("command not latched");
   a_param_write_latch: assert property (reg_wr && host_addr_i == 2'h1 |=>
      !param_valid_o || param_byte_o == $past(host_wdata_i)) else $error("parameter lost");
   a_imm_read_value: assert property (reg_rd && host_addr_i == 2'h1 &&
      !imm_result_valid_i |=> host_rdata_o == $past(last_imm_q))
      else $error("immediate result wrong");
   a_tx_dma_level: assert property (tx_dma_req_o ==
      (!irq_transfer_mode_i && tx_xfer_req_i)) else $error("tx dma request wrong");
   a_tx_data_pulse: assert property (ce_i && tx_transfer_acknowledge_i && host_wr_i |=>
      tx_data_valid_o && tx_data_o == $past(host_wdata_i)) else $error("tx data not passed");
   a_tx_push_int: assert property (ce_i && tx_result_valid_i && tx_result_ready_o
      |=> tx_interrupt_request_o && !tx_result_ready_o) else $error("tx result not flagged");
   a_rx_avail_int: assert property (!rx_result_ready_o |-> rx_interrupt_request_o)
      else $error("rx result without interrupt");
   a_rx_int_holds: assert property (rx_interrupt_request_o && !rx_result_ready_o &&
      !(reg_rd && host_addr_i == 2'h3) |=> rx_interrupt_request_o) else $error("rx int dropped");
   a_tx_int_drops: assert property (reg_rd && host_addr_i == 2'h2 &&
      !tx_result_valid_i ##1 !(irq_transfer_mode_i && tx_xfer_req_i) |-> !tx_interrupt_request_o)
      else $error("tx int stuck after result read");
endmodule

bind hdlc_host_port hdlc_port_checker chk (
   .core_clk_i, .sys_rst_i, .ce_i, .host_cs_i, .host_rd_i, .host_wr_i, .host_addr_i,
   .host_wdata_i, .rx_transfer_acknowledge_i, .tx_transfer_acknowledge_i, .host_rdata_o,
   .tx_interrupt_request_o, .rx_interrupt_request_o, .irq_transfer_mode_i, .tx_dma_req_o,
   .cmd_valid_o, .cmd_byte_o, .param_valid_o, .param_byte_o, .imm_result_valid_i,
   .imm_result_i, .tx_xfer_req_i, .tx_data_valid_o, .tx_data_o, .tx_result_valid_i,
   .tx_result_ready_o, .rx_result_ready_o
);

// ==== verification/hdlc_host_port_tb.sv ====
/*
 Self-checking bench for the host command/result port.
 Assumes the host model and the checker are compiled before it.
*/
module hdlc_host_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] c; logic [7:0] p; logic [7:0] r;} row_s;
   localparam row_s ROWS [3] = '{'{8'h91, 8'h05, 8'h3C}, '{8'hA4, 8'h80, 8'hC3},
                                 '{8'h57, 8'hFF, 8'h00}};
   logic core_clk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic irqm = 1'h0;
   logic txreq = 1'h0;
   logic ce = 1'h1;
   logic nop = 1'h0;
   logic [7:0] ex = 8'h00;
   logic [7:0] xd = 8'h00;
   logic cs, rd, wr, rxack, txack, ok;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, q, cmd_byte, param_byte, tx_data;
   logic tx_int, rx_int, tx_dma, rx_dma, cmd_valid, param_valid, tx_dv, tx_rdy, rx_rdy, rxd_rdy;
   int n_fail = 0;
   int checked = 0;
   always #12.5 core_clk_i = ~core_clk_i;
   hdlc_host_port dut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
      .host_cs_i(cs), .host_rd_i(rd), .host_wr_i(wr), .host_addr_i(addr),
      .host_wdata_i(wdata), .rx_transfer_acknowledge_i(rxack),
      .tx_transfer_acknowledge_i(txack), .host_rdata_o(rdata),
      .tx_interrupt_request_o(tx_int), .rx_interrupt_request_o(rx_int),
      .irq_transfer_mode_i(irqm), .tx_dma_req_o(tx_dma), .rx_dma_req_o(rx_dma),
      .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte), .cmd_take_i(ex[0]),
      .cmd_noparam_i(nop), .param_valid_o(param_valid), .param_byte_o(param_byte),
      .param_take_i(ex[1]), .param_last_i(ex[2]), .imm_result_valid_i(ex[3]),
      .imm_result_i(xd), .tx_xfer_req_i(txreq), .tx_data_valid_o(tx_dv), .tx_data_o(tx_data),
      .tx_result_valid_i(ex[4]), .tx_result_i(xd), .tx_result_ready_o(tx_rdy),
      .rx_result_valid_i(ex[5]), .rx_result_i(xd), .rx_result_last_i(ex[6]),
      .rx_result_ready_o(rx_rdy), .rx_data_valid_i(ex[7]), .rx_data_i(xd),
      .rx_data_ready_o(rxd_rdy)
   );
   host_cpu_model host (
      .core_clk_i(core_clk_i), .rdata_i(rdata), .cs_o(cs), .rd_o(rd), .wr_o(wr),
      .addr_o(addr), .wdata_o(wdata), .rx_ack_o(rxack), .tx_ack_o(txack)
   );
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   // Executor strobes: one-cycle pulse with its data byte
   task automatic step(input logic [7:0] m, input logic [7:0] d);
      @(posedge core_clk_i);
      ex <= m;
      xd <= d;
      @(posedge core_clk_i);
      ex <= 8'h00;
      #1;
   endtask
   task automatic rd_reg(input logic [1:0] a);
      host.access(1'h0, a, 8'h00, 1'h0, 1'h0, q);
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      host.access(1'h1, a, d, 1'h0, 1'h0, q);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge core_clk_i);
      sys_rst_i <= 1'h0;
      rd_reg(2'h0);
      check({q, rx_rdy, tx_rdy}, {8'h00, 2'h3});
      $display("reset test done");
      for (int i = 0; i < 3; i++)
      begin
         host.poll(7, 1'h0, ok);
         check(ok, 1'h1);
         wr_reg(2'h0, ROWS[i].c);
         check({cmd_valid, cmd_byte}, {1'h1, ROWS[i].c});
         step(8'h01, xd);
         host.poll(5, 1'h0, ok);
         check(ok, 1'h1);
         wr_reg(2'h1, ROWS[i].p);
         check({param_valid, param_byte}, {1'h1, ROWS[i].p});
         rd_reg(2'h0);
         check({q[7], q[5]}, 2'h3);
         step(8'h06, xd);
         rd_reg(2'h0);
         check({q[7], q[5]}, 2'h0);
         step(8'h08, ROWS[i].r);
         host.poll(4, 1'h1, ok);
         check(ok, 1'h1);
         rd_reg(2'h1);
         check(q, ROWS[i].r);
         rd_reg(2'h0);
         check(q[4], 1'h0);
      end
      $display("table test done");
      wr_reg(2'h0, 8'h11);
      wr_reg(2'h0, 8'h22);
      check(cmd_byte, 8'h22);
      step(8'h01, xd);
      wr_reg(2'h1, 8'h33);
      wr_reg(2'h1, 8'h44);
      check(param_byte, 8'h44);
      step(8'h06, xd);
      rd_reg(2'h0);
      check(q[7], 1'h0);
      $display("overwrite test done");
      @(posedge core_clk_i);
      irqm <= 1'h1;
      txreq <= 1'h1;
      rd_reg(2'h0);
      check({tx_int, tx_dma, q[2], q[0]}, 4'hA);
      host.access(1'h1, 2'h0, 8'h5A, 1'h0, 1'h1, q);
      check({tx_dv, tx_data}, {1'h1, 8'h5A});
      @(posedge core_clk_i);
      txreq <= 1'h0;
      // Both sides complete at once; they must not disturb each other
      step(8'h30, 8'hA1);
      rd_reg(2'h0);
      check(q[3:0], 4'hF);
      rd_reg(2'h2);
      check({q, tx_int, rx_int}, {8'hA1, 2'h1});
      rd_reg(2'h3);
      check({q, rx_int}, {8'hA1, 1'h1});
      step(8'h60, 8'hB2);
      rd_reg(2'h3);
      check({q, rx_int}, {8'hB2, 1'h0});
      $display("result test done");
      for (int k = 0; k < 5; k++)
      begin
         if (k == 4)
            check(rxd_rdy, 1'h0);
         step(8'h80, 8'hD0 + 8'(k));
      end
      rd_reg(2'h0);
      check({rx_int, q[1]}, 2'h2);
      for (int k = 0; k < 5; k++)
      begin
         host.access(1'h0, 2'h0, 8'h00, 1'h1, 1'h0, q);
         check(q, k < 4 ? 8'hD0 + 8'(k) : 8'h00);
      end
      check(rx_int, 1'h0);
      $display("fifo test done");
      @(posedge core_clk_i);
      irqm <= 1'h0;
      step(8'h80, 8'h77);
      check({rx_dma, rx_int}, 2'h2);
      host.access(1'h0, 2'h0, 8'h00, 1'h1, 1'h0, q);
      check({q, rx_dma}, {8'h77, 1'h0});
      $display("dma test done");
      // A write while frozen must leave no trace
      @(posedge core_clk_i);
      ce <= 1'h0;
      wr_reg(2'h0, 8'hA0);
      @(posedge core_clk_i);
      ce <= 1'h1;
      nop <= 1'h1;
      rd_reg(2'h0);
      check({q[7], cmd_valid}, 2'h0);
      wr_reg(2'h0, 8'h64);
      rd_reg(2'h0);
      check(q[7:6], 2'h3);
      step(8'h01, xd);
      rd_reg(2'h0);
      check({q[7:6], cmd_valid}, 3'h0);
      wr_reg(2'h0, 8'h97);
      @(posedge core_clk_i);
      sys_rst_i <= 1'h1;
      @(posedge core_clk_i);
      sys_rst_i <= 1'h0;
      rd_reg(2'h0);
      check({q, cmd_valid, tx_rdy}, {8'h00, 2'h1});
      $display("enable and reset test done");
      tally_and_finish();
   end
   // Far beyond the fewer than two hundred cycles the tests need
   initial
   begin
      repeat (4000) @(posedge core_clk_i);
      n_fail++;
      tally_and_finish();
   end
endmodule

// ==== verification/host_cpu_model.sv ====
/*
 Host processor model: one parallel bus access at a time.
 Assumes the port samples strobes on the rising clock edge.
*/
module host_cpu_model (
   input wire logic core_clk_i,
   input wire logic [7:0] rdata_i,
   output logic cs_o,
   output logic rd_o,
   output logic wr_o,
   output logic [1:0] addr_o,
   output logic [7:0] wdata_o,
   output logic rx_ack_o,
   output logic tx_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {cs_o, rd_o, wr_o, rx_ack_o, tx_ack_o} = 5'h00;
      addr_o = 2'h0;
      wdata_o = 8'hA5;
   end
   // Strictly serial, so only one bus access is ever in flight
   task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d,
                         input logic rx, input logic tx, output logic [7:0] q);
      @(posedge core_clk_i);
      cs_o <= ~(rx | tx);
      rd_o <= ~w;
      wr_o <= w;
      addr_o <= a;
      wdata_o <= w ? d : ~wdata_o;
      rx_ack_o <= rx;
      tx_ack_o <= tx;
      @(posedge core_clk_i);
      {cs_o, rd_o, wr_o, rx_ack_o, tx_ack_o} <= 5'h00;
      // Released bus must not keep showing the old byte
      wdata_o <= ~wdata_o;
      #1 q = rdata_i;
   endtask
   // Bounded, so a stuck flag shows as a failed poll rather than a hang
   task automatic poll(input int b, input logic v, output logic ok);
      logic [7:0] s;
      ok = 1'h0;
      for (int i = 0; i < 16 && !ok; i++)
      begin
         access(1'h0, 2'h0, 8'h00, 1'h0, 1'h0, s);
         ok = s[b] === v;
      end
   endtask
endmodule

// ==== verilog/byte_stream_if.sv ====
/*
 Valid/ready word stream between the port's own modules.
 Assumes both ends share core_clk_i; a word moves when valid and ready are high.
*/
interface byte_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== verilog/hdlc_host_port.sv ====
/*
 Host command, execution and result handshake of the serial link controller:
 command and parameter registers, immediate result register, per-direction
 completion results, interrupts, status, and the receive data FIFO.
 Assumes synchronous one-cycle host strobes and executors that obey the
 valid/ready handshakes shown on the ports.
*/
// Summary of operation
// - One command register serves both directions; one command sequence at a time.
// - Transmitter and receiver run concurrently with own interrupt and result register.
// - DMA mode moves data by requests; otherwise interrupts or status signal transfers.
// - Interrupt mode raises the interrupt of the side needing transfer or reporting.
// - Result-available reads zero for transfer requests, one for completions.
// - Status mirrors both interrupt requests for polling hosts.
// - Result phase starts on successful completion or on execution error.
// - Immediate results go only to the immediate result register, without delay.
// - Immediate result full flags a valid result; host polls it then reads.
// - Transmit and receive results use separate registers and available bits.
// - A result is one cause byte plus optional further information bytes.
// - Interrupt stays asserted until the host has read every pending result byte.
// - A transmitter operation reports exactly one result byte.
// - Receive data is read through a dedicated port selected by transfer acknowledge.
// - Command busy sets on command write, clears when last parameter or a parameterless command is accepted.
// - Parameter full sets on write, clears on take; rewriting overwrites earlier byte.
// - Available flags set on result placement and clear when the host reads.
module hdlc_host_port (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic host_cs_i,
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   input wire logic [hdlc_port_pkg::ADDR_W-1:0] host_addr_i,
   input wire logic [hdlc_port_pkg::DATA_W-1:0] host_wdata_i,
   input wire logic rx_transfer_acknowledge_i,
   input wire logic tx_transfer_acknowledge_i,
   output logic [hdlc_port_pkg::DATA_W-1:0] host_rdata_o,
   output logic tx_interrupt_request_o,
   output logic rx_interrupt_request_o,
   input wire logic irq_transfer_mode_i,
   output logic tx_dma_req_o,
   output logic rx_dma_req_o,
   output logic cmd_valid_o,
   output logic [hdlc_port_pkg::DATA_W-1:0] cmd_byte_o,
   input wire logic cmd_take_i,
   input wire logic cmd_noparam_i,
   output logic param_valid_o,
   output logic [hdlc_port_pkg::DATA_W-1:0] param_byte_o,
   input wire logic param_take_i,
   input wire logic param_last_i,
   input wire logic imm_result_valid_i,
   input wire logic [hdlc_port_pkg::DATA_W-1:0] imm_result_i,
   input wire logic tx_xfer_req_i,
   output logic tx_data_valid_o,
   output logic [hdlc_port_pkg::DATA_W-1:0] tx_data_o,
   input wire logic tx_result_valid_i,
   input wire logic [hdlc_port_pkg::DATA_W-1:0] tx_result_i,
   output logic tx_result_ready_o,
   input wire logic rx_result_valid_i,
   input wire logic [hdlc_port_pkg::DATA_W-1:0] rx_result_i,
   input wire logic rx_result_last_i,
   output logic rx_result_ready_o,
   input wire logic rx_data_valid_i,
   input wire logic [hdlc_port_pkg::DATA_W-1:0] rx_data_i,
   output logic rx_data_ready_o
);
   typedef enum logic [1:0] {
      CMD_IDLE,
      CMD_WAIT_TAKE,
      CMD_PARAMS
   } cmd_state_e;

   cmd_state_e cmd_state_q;
   cmd_state_e cmd_state_d;
   logic [7:0] cmd_q;
   logic cmd_full_q;
   logic [7:0] param_q;
   logic param_full_q;
   logic [7:0] imm_q;
   logic imm_full_q;
   logic [7:0] rdata_q;
   logic [7:0] tx_data_q;
   logic tx_data_valid_q;

   logic [7:0] status_w;
   logic [7:0] tx_result_w;
   logic [7:0] rx_result_w;
   logic tx_avail_w;
   logic rx_avail_w;
   logic tx_int_w;
   logic rx_int_w;

   // Register access decode, shared by read and write paths
   function automatic logic reg_hit(input logic cs, input logic strobe,
                                    input logic [1:0] addr, input logic [1:0] target);
      reg_hit = cs & strobe & (addr == target);
   endfunction

   // Acknowledged transfers take priority over a register access
   wire rx_dack_rd = rx_transfer_acknowledge_i & host_rd_i;
   wire tx_dack_wr = tx_transfer_acknowledge_i & host_wr_i;
   wire reg_cs = host_cs_i & !rx_transfer_acknowledge_i & !tx_transfer_acknowledge_i;

   wire cmd_wr = reg_hit(reg_cs, host_wr_i, host_addr_i, hdlc_port_pkg::ADDR_CMD_STATUS);
   wire param_wr = reg_hit(reg_cs, host_wr_i, host_addr_i, hdlc_port_pkg::ADDR_PARAM_RESULT);
   wire status_rd = reg_hit(reg_cs, host_rd_i, host_addr_i, hdlc_port_pkg::ADDR_CMD_STATUS);
   wire imm_rd = reg_hit(reg_cs, host_rd_i, host_addr_i, hdlc_port_pkg::ADDR_PARAM_RESULT);
   wire tx_res_rd = reg_hit(reg_cs, host_rd_i, host_addr_i, hdlc_port_pkg::ADDR_TX_RESULT);
   wire rx_res_rd = reg_hit(reg_cs, host_rd_i, host_addr_i, hdlc_port_pkg::ADDR_RX_RESULT);

   wire cmd_accept = cmd_full_q & cmd_take_i & (cmd_state_q == CMD_WAIT_TAKE);
   wire param_accept = param_valid_o & param_take_i;

   // Command phase sequencing; a new command restarts the phase
   always_comb
   begin
      cmd_state_d = cmd_state_q;
      case (cmd_state_q)
         CMD_IDLE:
            if (cmd_wr)
               cmd_state_d = CMD_WAIT_TAKE;
         CMD_WAIT_TAKE:
            if (cmd_wr)
               cmd_state_d = CMD_WAIT_TAKE;
            else if (cmd_accept)
               cmd_state_d = cmd_noparam_i ? CMD_IDLE : CMD_PARAMS;
         CMD_PARAMS:
            if (cmd_wr)
               cmd_state_d = CMD_WAIT_TAKE;
            else if (param_accept && param_last_i)
               cmd_state_d = CMD_IDLE;
         default:
            cmd_state_d = CMD_IDLE;
      endcase
   end

   // Single command register shared by both directions
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         cmd_state_q <= CMD_IDLE;
         cmd_q <= hdlc_port_pkg::BYTE_RESET;
         cmd_full_q <= 1'b0;
      end
      else if (ce_i)
      begin
         cmd_state_q <= cmd_state_d;
         if (cmd_wr)
            cmd_q <= host_wdata_i;
         cmd_full_q <= cmd_wr | (cmd_full_q & !cmd_accept);
      end
   end

   // Parameter register; a write in the take cycle still counts
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         param_q <= hdlc_port_pkg::BYTE_RESET;
         param_full_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (param_wr)
            param_q <= host_wdata_i;
         param_full_q <= param_wr | (param_full_q & !param_accept);
      end
   end

   // Immediate result register; never loaded by the direction executors
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         imm_q <= hdlc_port_pkg::BYTE_RESET;
         imm_full_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (imm_result_valid_i)
            imm_q <= imm_result_i;
         imm_full_q <= imm_result_valid_i | (imm_full_q & !imm_rd);
      end
   end

   assign cmd_valid_o = cmd_full_q & (cmd_state_q == CMD_WAIT_TAKE);
   assign cmd_byte_o = cmd_q;
   // Parameters are only offered once the command itself was taken
   assign param_valid_o = param_full_q & (cmd_state_q == CMD_PARAMS);
   assign param_byte_o = param_q;

   // Transmit data written through the transmit acknowledge
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_data_q <= hdlc_port_pkg::BYTE_RESET;
         tx_data_valid_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (tx_dack_wr)
            tx_data_q <= host_wdata_i;
         tx_data_valid_q <= tx_dack_wr;
      end
   end

   assign tx_data_o = tx_data_q;
   assign tx_data_valid_o = tx_data_valid_q;

   // Receive data buffering; full FIFO stalls the receiver
   byte_stream_if #(.W(hdlc_port_pkg::DATA_W)) rx_in_if ();
   byte_stream_if #(.W(hdlc_port_pkg::DATA_W)) rx_out_if ();

   assign rx_in_if.valid = rx_data_valid_i;
   assign rx_in_if.data = rx_data_i;
   assign rx_data_ready_o = rx_in_if.ready;
   assign rx_out_if.ready = rx_dack_rd;

   stream_fifo #(
      .WIDTH(hdlc_port_pkg::DATA_W),
      .DEPTH(hdlc_port_pkg::RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .in_if(rx_in_if),
      .out_if(rx_out_if)
   );

   // Per-direction completion results
   byte_stream_if #(.W(hdlc_port_pkg::RES_W)) tx_res_if ();
   byte_stream_if #(.W(hdlc_port_pkg::RES_W)) rx_res_if ();

   // Successful or failed completion both arrive as a pushed result
   assign tx_res_if.valid = tx_result_valid_i;
   assign tx_res_if.data = {1'b1, tx_result_i};
   assign tx_result_ready_o = tx_res_if.ready;
   assign rx_res_if.valid = rx_result_valid_i;
   assign rx_res_if.data = {rx_result_last_i, rx_result_i};
   assign rx_result_ready_o = rx_res_if.ready;

   side_result #(.ONE_RESULT(1'b1)) u_tx_side (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .res_if(tx_res_if),
      .host_read_i(tx_res_rd),
      .xfer_req_i(tx_xfer_req_i),
      .irq_mode_i(irq_transfer_mode_i),
      .result_o(tx_result_w),
      .avail_o(tx_avail_w),
      .int_o(tx_int_w)
   );

   side_result #(.ONE_RESULT(1'b0)) u_rx_side (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .res_if(rx_res_if),
      .host_read_i(rx_res_rd),
      .xfer_req_i(rx_out_if.valid),
      .irq_mode_i(irq_transfer_mode_i),
      .result_o(rx_result_w),
      .avail_o(rx_avail_w),
      .int_o(rx_int_w)
   );

   assign tx_interrupt_request_o = tx_int_w;
   assign rx_interrupt_request_o = rx_int_w;

   // DMA mode asks for transfers without involving the host CPU
   assign tx_dma_req_o = !irq_transfer_mode_i & tx_xfer_req_i;
   assign rx_dma_req_o = !irq_transfer_mode_i & rx_out_if.valid;

   // Status word; the interrupt bits let a polling host skip the pins
   assign status_w[hdlc_port_pkg::ST_CMD_BUSY] = (cmd_state_q != CMD_IDLE);
   assign status_w[hdlc_port_pkg::ST_CMD_FULL] = cmd_full_q;
   assign status_w[hdlc_port_pkg::ST_PARAM_FULL] = param_full_q;
   assign status_w[hdlc_port_pkg::ST_IMM_FULL] = imm_full_q;
   assign status_w[hdlc_port_pkg::ST_RX_INT] = rx_int_w;
   assign status_w[hdlc_port_pkg::ST_TX_INT] = tx_int_w;
   assign status_w[hdlc_port_pkg::ST_RX_AVAIL] = rx_avail_w;
   assign status_w[hdlc_port_pkg::ST_TX_AVAIL] = tx_avail_w;

   wire [7:0] rdata_d = rx_dack_rd ? (rx_out_if.valid ? rx_out_if.data
                                                      : hdlc_port_pkg::UNMAPPED_READ)
                      : status_rd ? status_w
                      : imm_rd ? imm_q
                      : tx_res_rd ? tx_result_w
                      : rx_res_rd ? rx_result_w
                      : hdlc_port_pkg::UNMAPPED_READ;

   // Read data held until the next read
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         rdata_q <= hdlc_port_pkg::BYTE_RESET;
      else if (ce_i && (host_rd_i && (host_cs_i || rx_transfer_acknowledge_i)))
         rdata_q <= rdata_d;
   end

   assign host_rdata_o = rdata_q;
endmodule

// ==== verilog/hdlc_port_pkg.sv ====
/*
 Constants shared by the host command/result port of the serial link
 controller: host port addresses, status bit positions, widths, reset values.
 Assumes one 40 MHz clock and synchronous, single-cycle host strobes.
*/
package hdlc_port_pkg;
   localparam int DATA_W = 8;
   localparam int RES_W = 9;
   localparam int ADDR_W = 2;
   localparam int RX_FIFO_DEPTH = 4;
   localparam int CLK_PERIOD_NS = 25;

   // Host port addresses (with chip select)
   localparam logic [1:0] ADDR_CMD_STATUS = 2'h0;
   localparam logic [1:0] ADDR_PARAM_RESULT = 2'h1;
   localparam logic [1:0] ADDR_TX_RESULT = 2'h2;
   localparam logic [1:0] ADDR_RX_RESULT = 2'h3;

   // Status bit positions
   localparam int ST_CMD_BUSY = 7;
   localparam int ST_CMD_FULL = 6;
   localparam int ST_PARAM_FULL = 5;
   localparam int ST_IMM_FULL = 4;
   localparam int ST_RX_INT = 3;
   localparam int ST_TX_INT = 2;
   localparam int ST_RX_AVAIL = 1;
   localparam int ST_TX_AVAIL = 0;

   // Position of the last-byte flag in a result push word
   localparam int RES_LAST_BIT = 8;

   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ==== verilog/side_result.sv ====
/*
 Completion result register, result-available flag and interrupt request
 for one direction (transmitter or receiver) of the link controller.
 Assumes the executor pushes one result byte at a time, flagged last or not.
*/
module side_result #(
   parameter bit ONE_RESULT = 1'b0
)(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   byte_stream_if.snk res_if,
   input wire logic host_read_i,
   input wire logic xfer_req_i,
   input wire logic irq_mode_i,
   output logic [7:0] result_o,
   output logic avail_o,
   output logic int_o
);
   logic [7:0] result_q;
   logic avail_q;
   logic more_q;

   // Next byte waits until the host has read the current one
   assign res_if.ready = !avail_q;
   wire push = res_if.valid & res_if.ready;
   wire push_last = ONE_RESULT | res_if.data[hdlc_port_pkg::RES_LAST_BIT];

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         result_q <= hdlc_port_pkg::BYTE_RESET;
         avail_q <= 1'b0;
         more_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (push)
         begin
            result_q <= res_if.data[7:0];
            more_q <= !push_last;
         end
         avail_q <= push | (avail_q & !host_read_i);
      end
   end

   assign result_o = result_q;
   assign avail_o = avail_q;
   // Held through every unread byte, dropped only when nothing is owed
   assign int_o = avail_q | more_q | (irq_mode_i & xfer_req_i);
endmodule

// ==== verilog/stream_fifo.sv ====
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes a single clock, synchronous active-high reset and a clock enable.
*/
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   byte_stream_if.snk in_if,
   byte_stream_if.src out_if
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;

   wire push = in_if.valid & in_if.ready;
   wire pop = out_if.valid & out_if.ready;

   assign in_if.ready = (count_q != FULL_CNT);
   assign out_if.valid = (count_q != '0);
   assign out_if.data = mem_q[rd_ptr_q];

   function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
      next_ptr = (p == LAST_PTR) ? '0 : PTR_W'(p + 1'b1);
   endfunction

   always_ff @(posedge core_clk_i)
   begin
      if (push && ce_i)
      begin
         mem_q[wr_ptr_q] <= in_if.data;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else if (ce_i)
      begin
         if (push)
            wr_ptr_q <= next_ptr(wr_ptr_q);
         if (pop)
            rd_ptr_q <= next_ptr(rd_ptr_q);
         if (push && !pop)
            count_q <= CNT_W'(count_q + 1'b1);
         else if (pop && !push)
            count_q <= CNT_W'(count_q - 1'b1);
      end
   end
endmodule
